// ==== rtl/rdc_pkg.sv ====
// Package for the reader direct command unit: codes, field layouts, records.
// Assumes one 50 MHz clock domain and a host port that delivers decoded words.
package rdc_pkg;

  // ****************************************
  // Host word layout
  // ****************************************
  localparam int RDC_CMD_BIT = 7;
  localparam int RDC_CODE_W = 5;

  // ****************************************
  // Command codes (command bit included)
  // ****************************************
  localparam logic [7:0] RDC_C_IDLE = 8'h80;
  localparam logic [7:0] RDC_C_HOP_MAIN = 8'h84;
  localparam logic [7:0] RDC_C_HOP_AUX = 8'h85;
  localparam logic [7:0] RDC_C_ADC = 8'h87;
  localparam logic [7:0] RDC_C_CAL = 8'h88;
  localparam logic [7:0] RDC_C_CAL_DEC = 8'h89;
  localparam logic [7:0] RDC_C_CAL_INC = 8'h8A;
  localparam logic [7:0] RDC_C_FIFO_RST = 8'h8F;
  localparam logic [7:0] RDC_C_TX_CRC = 8'h90;
  localparam logic [7:0] RDC_C_TX_HDR = 8'h91;
  localparam logic [7:0] RDC_C_TX_NOCRC = 8'h92;
  localparam logic [7:0] RDC_C_DTX_CRC = 8'h93;
  localparam logic [7:0] RDC_C_DTX_NOCRC = 8'h94;
  localparam logic [7:0] RDC_C_RX_BLOCK = 8'h96;
  localparam logic [7:0] RDC_C_RX_ENABLE = 8'h97;
  localparam logic [7:0] RDC_C_QUERY = 8'h98;
  localparam logic [7:0] RDC_C_GEN2_FIRST = 8'h99;
  localparam logic [7:0] RDC_C_GEN2_LAST = 8'h9F;

  // ****************************************
  // Converter source select
  // ****************************************
  localparam logic [2:0] RDC_SRC_MIX1 = 3'h1;
  localparam logic [2:0] RDC_SRC_MIX2 = 3'h2;
  localparam logic [2:0] RDC_SRC_PIN = 3'h3;

  // ****************************************
  // Widths and limits
  // ****************************************
  localparam int RDC_CAL_W = 4;
  localparam logic [3:0] RDC_CAL_MAX = 4'hF;
  localparam logic [3:0] RDC_CAL_MIN = 4'h0;
  // Mid-scale start so both step directions are open after reset
  localparam logic [3:0] RDC_CAL_RST = 4'h8;
  localparam logic [1:0] RDC_TX_START_BYTES = 2'h3;
  localparam int RDC_LEN_W = 12;
  localparam int RDC_WAIT_W = 8;
  localparam logic [7:0] RDC_WAIT_ZERO = 8'h00;

  // ****************************************
  // Records
  // ****************************************
  // Transmit length as loaded by the host
  typedef struct packed {
    logic [11:0] bytes;
    logic [2:0] bits;
    logic partial;
  } rdc_txlen_s;

  // Frame options handed to the transmitter
  typedef struct packed {
    logic crc16;
    logic crc5;
    logic hdr_bit;
    logic rx_no_crc;
    logic [7:0] code;
  } rdc_txopt_s;

  typedef enum logic [3:0] {
    RDC_TX_IDLE = 4'b0001,
    RDC_TX_LOAD = 4'b0010,
    RDC_TX_WAIT = 4'b0100,
    RDC_TX_SEND = 4'b1000
  } rdc_tx_e;

endpackage : rdc_pkg

// ==== rtl/rdc_wait_timer.sv ====
// Down counter for the delayed transmit and receive wait times.
// Assumes the load and tick inputs come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module rdc_wait_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Control
  input wire logic i_load,
  input wire logic [rdc_pkg::RDC_WAIT_W-1:0] i_value,
  input wire logic i_tick,
  // Status
  output logic o_busy,
  output logic o_done
);
  import rdc_pkg::*;

  logic [RDC_WAIT_W-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;

  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (i_load) begin
      cnt_next = i_value;
      done_next = (i_value == RDC_WAIT_ZERO);
    end else if (i_tick && cnt_reg != RDC_WAIT_ZERO) begin
      cnt_next = cnt_reg - 8'h01;
      done_next = (cnt_reg == 8'h01);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg <= RDC_WAIT_ZERO;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign o_busy = (cnt_reg != RDC_WAIT_ZERO);
  assign o_done = done_reg;

endmodule : rdc_wait_timer
`default_nettype wire

// ==== rtl/rdc_cmd_unit.sv ====
// Direct command interpreter of the reader: decodes host words into actions.
// Assumes the host port has framed words; registers live outside as ports.
// Notes on behaviour
// - Commands carry bit 7 set; 80 hex is idle and does nothing.
// - 84 selects main PLL divider (reset default); 85 selects auxiliary.
// - 87 starts one 8-bit conversion; result goes to readout register.
// - Source select 001 mixer one, 010 mixer two, 011 pin; others test.
// - 88 runs filter calibration and stores the result in calibration.
// - 89 steps calibration down, 8A up; sixteen steps of four percent.
// - Target select bit picks low-pass or high-pass part for steps.
// - 8F resets FIFO pointers, all interrupt flags and error location.
// - Send starts at third FIFO byte, or when shorter message completes.
// - Command 90 appends CRC-16 over the payload.
// - 91 sends like 90 and tells receiver to expect header bit.
// - 92 sends like 90 with no CRC appended.
// - 93 sends with CRC when the preloaded wait time expires.
// - Delayed wait counts from end of previous reception, not command.
// - 94 is delayed transmit without CRC.
// - 96 holds receiver decoder and framer in reset; no receive events.
// - Hold ends on command 97 or at end of a transmit.
// - Nonzero receive wait keeps receiver held after transmit until done.
// - 98 sends Query with CRC5; reply taken without CRC check.
// - 99 to 9C query frames no CRC; 9D ACK, 9E NAK, 9F ReqRN.
// - Length is 12-bit byte count, 3-bit bit count, partial flag.
// - Host word bit 7 marks command; low five bits hold the code.
`timescale 1ns/1ps
`default_nettype none
module rdc_cmd_unit (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Host words
  input wire logic i_word_valid,
  input wire logic [7:0] i_word,
  // Transmit length and FIFO write
  input wire rdc_pkg::rdc_txlen_s i_txlen,
  input wire logic i_fifo_wr,
  // Configuration
  input wire logic [2:0] i_adc_src_sel,
  input wire logic i_cal_adjust_target_select,
  input wire logic [rdc_pkg::RDC_WAIT_W-1:0] i_tx_wait,
  input wire logic [rdc_pkg::RDC_WAIT_W-1:0] i_rx_wait,
  // Analog and air side status (same clock)
  input wire logic i_adc_done,
  input wire logic [7:0] i_adc_data,
  input wire logic i_cal_done,
  input wire logic [3:0] i_cal_result,
  input wire logic i_rx_end,
  input wire logic i_tx_end,
  input wire logic i_wait_tick,
  // Control outputs
  output logic o_pll_aux_sel,
  output logic o_adc_start,
  output logic [2:0] o_adc_src,
  output logic [7:0] o_adc_readout,
  output logic o_cal_start,
  output logic [3:0] o_cal_lp,
  output logic [3:0] o_cal_hp,
  output logic o_fifo_reset,
  output logic o_irq_clear,
  output logic o_err_loc_clear,
  output logic o_tx_start,
  output rdc_pkg::rdc_txopt_s o_tx_opt,
  output logic o_rx_hold
);
  import rdc_pkg::*;

  // ****************************************
  // Command decode
  // ****************************************
  logic is_cmd;
  logic [7:0] cmd;
  logic c_tx_imm, c_tx_dly, c_gen2, c_query;
  assign is_cmd = i_word_valid && i_word[RDC_CMD_BIT];
  assign cmd = {1'b1, 2'b00, i_word[RDC_CODE_W-1:0]};
  assign c_tx_imm = is_cmd && (cmd == RDC_C_TX_CRC || cmd == RDC_C_TX_HDR ||
                    cmd == RDC_C_TX_NOCRC);
  assign c_tx_dly = is_cmd && (cmd == RDC_C_DTX_CRC ||
                    cmd == RDC_C_DTX_NOCRC);
  assign c_query = is_cmd && cmd == RDC_C_QUERY;
  assign c_gen2 = is_cmd && cmd >= RDC_C_GEN2_FIRST &&
                  cmd <= RDC_C_GEN2_LAST;

  // ****************************************
  // Misc control state
  // ****************************************
  logic pll_reg, pll_next;
  logic [2:0] src_reg, src_next;
  logic [7:0] adc_reg, adc_next;
  logic [3:0] lp_reg, lp_next, hp_reg, hp_next;
  logic adc_st_next, cal_st_next, fifo_next;
  logic adc_st_reg, cal_st_reg, fifo_reg;

  always_comb begin
    pll_next = pll_reg;
    src_next = src_reg;
    adc_next = adc_reg;
    lp_next = lp_reg;
    hp_next = hp_reg;
    adc_st_next = 1'b0;
    cal_st_next = 1'b0;
    fifo_next = 1'b0;
    if (i_adc_done) begin
      adc_next = i_adc_data;
    end
    if (i_cal_done) begin
      if (i_cal_adjust_target_select) begin
        hp_next = i_cal_result;
      end else begin
        lp_next = i_cal_result;
      end
    end
    if (is_cmd) begin
      case (cmd)
        RDC_C_HOP_MAIN: pll_next = 1'b0;
        RDC_C_HOP_AUX: pll_next = 1'b1;
        RDC_C_ADC: begin
          adc_st_next = 1'b1;
          src_next = i_adc_src_sel;
        end
        RDC_C_CAL: cal_st_next = 1'b1;
        RDC_C_CAL_DEC: begin
          if (i_cal_adjust_target_select) begin
            if (hp_reg != RDC_CAL_MIN) hp_next = hp_reg - 4'h1;
          end else if (lp_reg != RDC_CAL_MIN) begin
            lp_next = lp_reg - 4'h1;
          end
        end
        RDC_C_CAL_INC: begin
          if (i_cal_adjust_target_select) begin
            if (hp_reg != RDC_CAL_MAX) hp_next = hp_reg + 4'h1;
          end else if (lp_reg != RDC_CAL_MAX) begin
            lp_next = lp_reg + 4'h1;
          end
        end
        RDC_C_FIFO_RST: fifo_next = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pll_reg <= 1'b0;
      src_reg <= 3'h0;
      adc_reg <= 8'h00;
      lp_reg <= RDC_CAL_RST;
      hp_reg <= RDC_CAL_RST;
      adc_st_reg <= 1'b0;
      cal_st_reg <= 1'b0;
      fifo_reg <= 1'b0;
    end else begin
      pll_reg <= pll_next;
      src_reg <= src_next;
      adc_reg <= adc_next;
      lp_reg <= lp_next;
      hp_reg <= hp_next;
      adc_st_reg <= adc_st_next;
      cal_st_reg <= cal_st_next;
      fifo_reg <= fifo_next;
    end
  end

  // ****************************************
  // Transmit sequencer
  // ****************************************
  rdc_tx_e st_reg, st_next;
  rdc_txopt_s opt_reg, opt_next;
  logic [RDC_LEN_W-1:0] cnt_reg, cnt_next;
  logic dly_reg, dly_next, go_reg, go_next;
  logic [RDC_LEN_W-1:0] need;
  logic tx_busy, tx_done, rx_busy, rx_done;

  // partial byte counts
  // Partial byte counts as one more FIFO byte
  assign need = i_txlen.bytes + {11'h000, i_txlen.partial};

  always_comb begin
    st_next = st_reg;
    opt_next = opt_reg;
    cnt_next = cnt_reg;
    dly_next = dly_reg;
    go_next = 1'b0;
    case (st_reg)
      RDC_TX_IDLE: begin
        cnt_next = '0;
        if (c_tx_imm || c_tx_dly) begin
          opt_next.crc16 = (cmd != RDC_C_TX_NOCRC &&
                            cmd != RDC_C_DTX_NOCRC);
          opt_next.crc5 = 1'b0;
          opt_next.hdr_bit = (cmd == RDC_C_TX_HDR);
          opt_next.rx_no_crc = 1'b0;
          opt_next.code = cmd;
          dly_next = c_tx_dly;
          st_next = RDC_TX_LOAD;
        end else if (c_query || c_gen2) begin
          opt_next.crc16 = 1'b0;
          opt_next.crc5 = c_query;
          opt_next.hdr_bit = 1'b0;
          opt_next.rx_no_crc = 1'b1;
          opt_next.code = cmd;
          dly_next = 1'b0;
          go_next = 1'b1;
          st_next = RDC_TX_SEND;
        end
      end
      RDC_TX_LOAD: begin
        if (i_fifo_wr) cnt_next = cnt_reg + 12'h001;
        if (cnt_next >= need || cnt_next == {10'h000, RDC_TX_START_BYTES})
        begin
          st_next = dly_reg ? RDC_TX_WAIT : RDC_TX_SEND;
          go_next = !dly_reg;
        end
      end
      RDC_TX_WAIT: begin
        if (tx_done || !tx_busy) begin
          go_next = 1'b1;
          st_next = RDC_TX_SEND;
        end
      end
      RDC_TX_SEND: begin
        if (i_tx_end) st_next = RDC_TX_IDLE;
      end
      default: st_next = RDC_TX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= RDC_TX_IDLE;
      opt_reg <= '0;
      cnt_reg <= '0;
      dly_reg <= 1'b0;
      go_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      opt_reg <= opt_next;
      cnt_reg <= cnt_next;
      dly_reg <= dly_next;
      go_reg <= go_next;
    end
  end

  // Started at reception end so a late command still meets the slot
  rdc_wait_timer u_tx_wait (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_load(i_rx_end),
    .i_value(i_tx_wait),
    .i_tick(i_wait_tick),
    .o_busy(tx_busy),
    .o_done(tx_done)
  );

  // ****************************************
  // Receiver hold
  // ****************************************
  logic hold_reg, hold_next, rxw_reg, rxw_next;

  rdc_wait_timer u_rx_wait (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_load(i_tx_end && i_rx_wait != RDC_WAIT_ZERO),
    .i_value(i_rx_wait),
    .i_tick(i_wait_tick),
    .o_busy(rx_busy),
    .o_done(rx_done)
  );

  always_comb begin
    hold_next = hold_reg;
    rxw_next = rxw_reg;
    if (i_tx_end) hold_next = 1'b0;
    if (i_tx_end && i_rx_wait != RDC_WAIT_ZERO) rxw_next = 1'b1;
    else if (rx_done || (rxw_reg && !rx_busy)) rxw_next = 1'b0;
    if (is_cmd && cmd == RDC_C_RX_BLOCK) hold_next = 1'b1;
    if (is_cmd && cmd == RDC_C_RX_ENABLE) hold_next = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_reg <= 1'b0;
      rxw_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      rxw_reg <= rxw_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_pll_aux_sel = pll_reg;
  assign o_adc_start = adc_st_reg;
  assign o_adc_src = src_reg;
  assign o_adc_readout = adc_reg;
  assign o_cal_start = cal_st_reg;
  assign o_cal_lp = lp_reg;
  assign o_cal_hp = hp_reg;
  assign o_fifo_reset = fifo_reg;
  assign o_irq_clear = fifo_reg;
  assign o_err_loc_clear = fifo_reg;
  assign o_tx_start = go_reg;
  assign o_tx_opt = opt_reg;
  assign o_rx_hold = hold_reg || rxw_reg;

  // ****************************************
  // Checks
  // ****************************************
  property p_hop;
    @(posedge i_clk) disable iff (!i_nrst)
      is_cmd && cmd == RDC_C_HOP_AUX |=> o_pll_aux_sel;
  endproperty
  a_hop: assert property (p_hop) else $error("aux hop missed");

  property p_fifo;
    @(posedge i_clk) disable iff (!i_nrst)
      is_cmd && cmd == RDC_C_FIFO_RST |=> o_fifo_reset && o_irq_clear
        && o_err_loc_clear ##1 !o_fifo_reset;
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo reset bad");

  property p_block;
    @(posedge i_clk) disable iff (!i_nrst)
      is_cmd && cmd == RDC_C_RX_BLOCK |=> o_rx_hold;
  endproperty
  a_block: assert property (p_block) else $error("rx not held");

  property p_dec;
    @(posedge i_clk) disable iff (!i_nrst)
      is_cmd && cmd == RDC_C_CAL_DEC && !i_cal_adjust_target_select &&
      !i_cal_done && lp_reg != RDC_CAL_MIN |=>
        o_cal_lp == $past(lp_reg) - 4'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("cal step wrong");

  property p_adc;
    @(posedge i_clk) disable iff (!i_nrst)
      is_cmd && cmd == RDC_C_ADC |=>
        o_adc_start && o_adc_src == $past(i_adc_src_sel);
  endproperty
  a_adc: assert property (p_adc) else $error("adc not started");

  property p_crc;
    @(posedge i_clk) disable iff (!i_nrst)
      st_reg == RDC_TX_IDLE && c_tx_imm |=> o_tx_opt.crc16 ==
        ($past(cmd) != RDC_C_TX_NOCRC);
  endproperty
  a_crc: assert property (p_crc) else $error("crc option wrong");

  property p_query;
    @(posedge i_clk) disable iff (!i_nrst)
      st_reg == RDC_TX_IDLE && c_query |=> o_tx_start && o_tx_opt.crc5
        && o_tx_opt.rx_no_crc;
  endproperty
  a_query: assert property (p_query) else $error("query bad");

  property p_ign;
    @(posedge i_clk) disable iff (!i_nrst)
      is_cmd && cmd == RDC_C_IDLE && !i_cal_done && !i_tx_end &&
      st_reg == RDC_TX_IDLE |=>
        $stable(o_pll_aux_sel) && $stable(o_cal_lp) && !o_tx_start;
  endproperty
  a_ign: assert property (p_ign) else $error("idle changed state");

  c_tx: cover property (@(posedge i_clk) disable iff (!i_nrst)
    st_reg == RDC_TX_LOAD ##[1:20] o_tx_start);
  c_dly: cover property (@(posedge i_clk) disable iff (!i_nrst)
    st_reg == RDC_TX_WAIT ##[1:300] o_tx_start);
  c_rxw: cover property (@(posedge i_clk) disable iff (!i_nrst)
    rxw_reg ##[1:300] !o_rx_hold);

endmodule : rdc_cmd_unit
`default_nettype wire

// ==== tb/rdc_host_model.sv ====
// Host side model: issues host words, transmit length and payload bytes.
// Assumes the bench calls its tasks; all changes land on falling edges.
`timescale 1ns/1ps
`default_nettype none
module rdc_host_model (
  // Clock
  input wire logic i_clk,
  // Host port
  output var logic o_word_valid,
  output var logic [7:0] o_word,
  output var rdc_pkg::rdc_txlen_s o_txlen,
  output var logic o_fifo_wr
);
  import rdc_pkg::*;
  initial begin
    o_word_valid = 1'b0;
    o_word = 8'h00;
    o_txlen = '0;
    o_fifo_wr = 1'b0;
  end
  task put_word(input logic [7:0] w);
    @(negedge i_clk);
    o_word_valid = 1'b1;
    o_word = w;
    @(negedge i_clk);
    o_word_valid = 1'b0;
    // Released word shows the inverse, never a stale copy
    o_word = ~w;
  endtask : put_word
  task load(input logic [11:0] n, input logic part);
    @(negedge i_clk);
    o_txlen = '{bytes: n, bits: part ? 3'h5 : 3'h0, partial: part};
  endtask : load
  task put_bytes(input int n);
    repeat (n) begin
      @(negedge i_clk);
      o_fifo_wr = 1'b1;
      @(negedge i_clk);
      o_fifo_wr = 1'b0;
    end
  endtask : put_bytes
endmodule : rdc_host_model
`default_nettype wire

// ==== tb/rdc_cmd_unit_bench.sv ====
// Bench for the direct command unit: table of single words, then sequences.
// Assumes the host model drives the host port; bench drives status inputs.
`timescale 1ns/1ps
`default_nettype none
module rdc_cmd_unit_bench;
  import rdc_pkg::*;
  typedef struct packed {
    logic [7:0] word;
    logic [6:0] exp;
  } rdc_row_s;
  typedef struct packed {
    logic [7:0] cmd;
    logic [11:0] bytes;
    logic partial;
    logic [7:0] rxw;
    logic [10:0] opt;
  } rdc_txrow_s;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_word_valid;
  logic i_fifo_wr;
  logic [7:0] i_word;
  rdc_txlen_s i_txlen;
  logic [2:0] sel = 3'h0;
  logic tgt = 1'b0;
  logic [7:0] txw = 8'h03;
  logic [7:0] rxw = 8'h00;
  logic [7:0] adc_d = 8'h00;
  logic [3:0] cal_r = 4'h0;
  // Event pulses: rx end, tx end, tick, adc done, cal done
  logic [4:0] evt = 5'h00;
  logic o_pll_aux_sel, o_adc_start, o_cal_start, o_fifo_reset;
  logic o_irq_clear, o_err_loc_clear, o_tx_start, o_rx_hold;
  logic [2:0] o_adc_src;
  logic [7:0] o_adc_readout;
  logic [3:0] o_cal_lp, o_cal_hp;
  rdc_txopt_s o_tx_opt;
  int err_count = 0;
  int comparisons = 0;
  int need;
  rdc_row_s rows [12];
  rdc_txrow_s txr [3];
  always #10 i_clk = ~i_clk;
  rdc_host_model rdc_host_model_inst (
    .i_clk(i_clk), .o_word_valid(i_word_valid), .o_word(i_word),
    .o_txlen(i_txlen), .o_fifo_wr(i_fifo_wr));
  rdc_cmd_unit rdc_cmd_unit_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_word_valid(i_word_valid),
    .i_word(i_word), .i_txlen(i_txlen), .i_fifo_wr(i_fifo_wr),
    .i_adc_src_sel(sel), .i_cal_adjust_target_select(tgt),
    .i_tx_wait(txw), .i_rx_wait(rxw), .i_adc_done(evt[3]),
    .i_adc_data(adc_d), .i_cal_done(evt[4]), .i_cal_result(cal_r),
    .i_rx_end(evt[0]), .i_tx_end(evt[1]), .i_wait_tick(evt[2]),
    .o_pll_aux_sel(o_pll_aux_sel), .o_adc_start(o_adc_start),
    .o_adc_src(o_adc_src), .o_adc_readout(o_adc_readout),
    .o_cal_start(o_cal_start), .o_cal_lp(o_cal_lp), .o_cal_hp(o_cal_hp),
    .o_fifo_reset(o_fifo_reset), .o_irq_clear(o_irq_clear),
    .o_err_loc_clear(o_err_loc_clear), .o_tx_start(o_tx_start),
    .o_tx_opt(o_tx_opt), .o_rx_hold(o_rx_hold));
  // ****************************************
  // Helpers
  // ****************************************
  task stop_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task ev(input int b, input int n);
    repeat (n) begin
      @(negedge i_clk);
      evt[b] = 1'b1;
      @(negedge i_clk);
      evt[b] = 1'b0;
    end
  endtask : ev
  // Bounded look for a start pulse; a missing one ends the run
  task watch(input int n, input logic want);
    logic s;
    s = 1'b0;
    repeat (n) begin
      s = s | (o_tx_start === 1'b1);
      @(negedge i_clk);
    end
    if (want && !s) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, s, want);
      stop_test();
    end else
      chk(s, want);
  endtask : watch
  function logic [6:0] obs();
    return {o_pll_aux_sel, o_adc_start, o_cal_start, o_fifo_reset,
      o_irq_clear, o_err_loc_clear, o_rx_hold};
  endfunction : obs
  function logic [26:0] rstv();
    return {obs(), o_tx_start, o_cal_lp, o_cal_hp, o_adc_readout, o_adc_src};
  endfunction : rstv
  function logic [10:0] optv();
    return {o_tx_opt.crc16, o_tx_opt.crc5, o_tx_opt.hdr_bit, o_tx_opt.code};
  endfunction : optv
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    rows = '{'{8'h85, 7'h40}, '{8'h84, 7'h00}, '{8'h87, 7'h20},
      '{8'h88, 7'h10}, '{8'h8F, 7'h0E}, '{8'h80, 7'h00}, '{8'h95, 7'h00},
      '{8'h05, 7'h00}, '{8'h96, 7'h01}, '{8'h97, 7'h00}, '{8'hC5, 7'h40},
      '{8'h84, 7'h00}};
    txr = '{'{8'h90, 12'h003, 1'b0, 8'h00, 11'h490},
      '{8'h91, 12'h002, 1'b0, 8'h00, 11'h591},
      '{8'h92, 12'h001, 1'b1, 8'h02, 11'h092}};
    cyc(2);
    chk(rstv(), {7'h00, 1'b0, 8'h88, 8'h00, 3'h0});
    i_nrst = 1'b1;
    foreach (rows[i]) begin
      rdc_host_model_inst.put_word(rows[i].word);
      chk(obs(), rows[i].exp);
    end
    for (int s = 1; s < 4; s++) begin
      sel = s[2:0];
      adc_d = {5'h15, s[2:0]};
      rdc_host_model_inst.put_word(RDC_C_ADC);
      chk(o_adc_src, sel);
      ev(3, 1);
      cyc(1);
      chk(o_adc_readout, adc_d);
    end
    cal_r = 4'h5;
    ev(4, 1);
    cyc(1);
    chk({o_cal_lp, o_cal_hp}, 8'h58);
    rdc_host_model_inst.put_word(RDC_C_CAL_DEC);
    chk({o_cal_lp, o_cal_hp}, 8'h48);
    tgt = 1'b1;
    // Eight raises from 8 must stop at the top step
    repeat (8) rdc_host_model_inst.put_word(RDC_C_CAL_INC);
    chk({o_cal_lp, o_cal_hp}, 8'h4F);
    tgt = 1'b0;
    repeat (5) rdc_host_model_inst.put_word(RDC_C_CAL_DEC);
    chk({o_cal_lp, o_cal_hp}, 8'h0F);
    foreach (txr[i]) begin
      rxw = txr[i].rxw;
      rdc_host_model_inst.load(txr[i].bytes, txr[i].partial);
      rdc_host_model_inst.put_word(RDC_C_RX_BLOCK);
      rdc_host_model_inst.put_word(txr[i].cmd);
      need = txr[i].bytes + txr[i].partial;
      rdc_host_model_inst.put_bytes(need - 1);
      watch(2, 1'b0);
      rdc_host_model_inst.put_bytes(1);
      watch(2, 1'b1);
      chk(optv(), txr[i].opt);
      // Query while sending must be dropped
      rdc_host_model_inst.put_word(RDC_C_QUERY);
      watch(3, 1'b0);
      chk(o_rx_hold, 1'b1);
      ev(1, 1);
      cyc(1);
      if (rxw != 8'h00) begin
        chk(o_rx_hold, 1'b1);
        ev(2, 1);
        cyc(1);
        chk(o_rx_hold, 1'b1);
        ev(2, 1);
        cyc(2);
      end
      chk(o_rx_hold, 1'b0);
    end
    rxw = 8'h00;
    for (int c = 8'h98; c <= 8'h9F; c++) begin
      rdc_host_model_inst.put_word(c[7:0]);
      watch(2, 1'b1);
      chk({o_tx_opt.crc16, o_tx_opt.crc5, o_tx_opt.code},
        {1'b0, c == 8'h98, c[7:0]});
      if (c < 8'h9D) chk(o_tx_opt.rx_no_crc, 1'b1);
      ev(1, 1);
    end
    for (int c = 8'h93; c < 8'h95; c++) begin
      rdc_host_model_inst.load(12'h001, 1'b0);
      // Wait already running before the command arrives
      ev(0, 1);
      ev(2, 1);
      rdc_host_model_inst.put_word(c[7:0]);
      rdc_host_model_inst.put_bytes(1);
      watch(3, 1'b0);
      ev(2, 2);
      watch(3, 1'b1);
      chk(o_tx_opt.crc16, c == 8'h93);
      ev(1, 1);
    end
    rdc_host_model_inst.put_word(RDC_C_HOP_AUX);
    rdc_host_model_inst.put_word(RDC_C_RX_BLOCK);
    i_nrst = 1'b0;
    cyc(1);
    chk(rstv(), {7'h00, 1'b0, 8'h88, 8'h00, 3'h0});
    i_nrst = 1'b1;
    stop_test();
  end
endmodule : rdc_cmd_unit_bench
`default_nettype wire
